/* File: rtl/rtcaw_consts.vh */
// Constants for the timekeeper core: register map, field masks, timing
`ifndef RTCAW_CONSTS_VH
`define RTCAW_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RTCAW_A_HUND     6'h00
`define RTCAW_A_SEC      6'h01
`define RTCAW_A_MIN      6'h02
`define RTCAW_A_AMIN     6'h03
`define RTCAW_A_HOUR     6'h04
`define RTCAW_A_AHOUR    6'h05
`define RTCAW_A_DAY      6'h06
`define RTCAW_A_ADAY     6'h07
`define RTCAW_A_DATE     6'h08
`define RTCAW_A_MONTH    6'h09
`define RTCAW_A_YEAR     6'h0a
`define RTCAW_A_CMD      6'h0b
`define RTCAW_A_WDLO     6'h0c
`define RTCAW_A_WDHI     6'h0d

// ****************************************************************
// Register bit masks: readable bits, stored month number bits, writable command bits
// ****************************************************************
`define RTCAW_M_SEC      8'h7f
`define RTCAW_M_MIN      8'h7f
`define RTCAW_M_HOUR     8'h7f
`define RTCAW_M_DAY      8'h07
`define RTCAW_M_ADAY     8'h87
`define RTCAW_M_DATE     8'h3f
`define RTCAW_M_MONTH    8'hdf
`define RTCAW_M_MONNUM   8'h1f
`define RTCAW_M_CMDWR    8'hfc

// ****************************************************************
// Field positions
// ****************************************************************
`define RTCAW_B_OSC_STOP 7
`define RTCAW_B_WAVE_OFF 6
`define RTCAW_B_H12      6
`define RTCAW_B_PM       5
`define RTCAW_B_AMASK    7
`define RTCAW_B_XFER     7
`define RTCAW_B_WDMASK   3
`define RTCAW_B_TDM      2
`define RTCAW_WAVE_BIT   1

// ****************************************************************
// Calendar limits and reset values (BCD)
// ****************************************************************
`define RTCAW_HUND_LAST  8'h99
`define RTCAW_HUND_PRE   8'h98
`define RTCAW_SEC_LAST   8'h59
`define RTCAW_H24_LAST   8'h23
`define RTCAW_H12_NOON   5'h12
`define RTCAW_H12_ELEVEN 5'h11
`define RTCAW_H12_ONE    5'h01
`define RTCAW_DAY_LAST   8'h07
`define RTCAW_MON_LAST   8'h12
`define RTCAW_ZERO       8'h00
`define RTCAW_ONE        8'h01
`define RTCAW_RST_MONTH  8'h81
`define RTCAW_RST_CMD    8'h80
// Idle pin levels: strobes high, the rest low, so reset makes no edge
`define RTCAW_PIN_IDLE   19'h1c000

// ****************************************************************
// Hundredths divider
// ****************************************************************
`define RTCAW_DIV_LONG   6'd41
`define RTCAW_DIV_SHORT  6'd40
`define RTCAW_DIV_STEPS  5'd25

`endif

/* File: rtl/rtcaw_core.v */
// Timekeeper core: hundredths divider, calendar, alarm, watchdog, host bus
// How it works
// - Oscillator divided 41 for 24 periods then 40 once, 100 Hz ticks
// - Time registers hold BCD; unused bits read zero
// - Months bit 7 set stops the oscillator
// - Months bit 6 clear drives 1024 Hz square wave, set floats it
// - Hours bit 6 selects 12-hour counting when one
// - Hours bit 5 is PM in 12-hour mode, tens bit in 24-hour
// - Visible time refreshed each hundredth unless frozen or oscillator off
// - Transfer enable low freezes visible copy; internal counters keep going
// - Seconds onward step at hundredths 99, copied out at 99 to 00
// - Alarm day bits 3 to 6 read zero
// - Bit 7 of alarm registers is a mask bit
// - Unmasked alarm needs minutes, hours and day all to match
// - Masks give daily, hourly, or every-minute alarms
// - Any alarm register access clears alarm flag and interrupt
// - Watchdog period is BCD up to 99.99 s, either access order
// - Watchdog register access reloads count, clears flag and interrupt
// - Watchdog counts down to zero, flags, reloads and repeats
// - Watchdog registers read back the stored period only
// - Zero period disables the watchdog
// - Host access ignored while supply below trip point
// - Read-only alarm and watchdog flags in command bits 0 and 1
// - Mask bits 3 and 2 gate interrupt outputs, not flags
`timescale 1ns/1ps
`include "rtcaw_consts.vh"
`default_nettype none

module rtcaw_core (
  input  wire       clk,                           // 10 MHz system clock
  input  wire       sys_rst,                       // Sync reset, active high
  input  wire       osc_in,                        // 4096 Hz oscillator pin
  input  wire       vcc_below_supply_trip_point,   // Main supply low
  input  wire       ce_n,                          // Chip enable, low
  input  wire       oe_n,                          // Output enable, low
  input  wire       we_n,                          // Write enable, low
  input  wire [5:0] addr,                          // Register address
  input  wire [7:0] dq_in,                         // Data pin input
  output reg  [7:0] dq_out,                        // Data pin output
  output wire       dq_oe,                         // Data pin drive enable
  output reg        square_wave_out,               // 1024 Hz output
  output reg        square_wave_oe,                // Square wave drive
  output reg        alarm_irq,                     // Alarm interrupt, high
  output reg        watchdog_irq                   // Watchdog irq, high
);

  localparam PW = 19;

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Per-bit filter: take new level once stages two and three agree
  function [PW-1:0] agree;
    input [PW-1:0] s2;
    input [PW-1:0] s3;
    input [PW-1:0] f;
    begin
      agree = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & f);
    end
  endfunction

  // BCD increment with wrap; bit 8 flags the wrap
  function [8:0] bcd_inc;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      if (v >= hi)
        bcd_inc = {1'b1, lo};
      else if (v[3:0] == 4'h9)
        bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Hours step in either format; bit 8 flags the day carry
  function [8:0] hour_inc;
    input [7:0] v;
    reg   [8:0] t;
    begin
      t = 9'h000;
      if (v[`RTCAW_B_H12]) begin
        if (v[4:0] == `RTCAW_H12_NOON)
          hour_inc = {1'b0, v[7:5], `RTCAW_H12_ONE};
        else if (v[4:0] == `RTCAW_H12_ELEVEN)
          hour_inc = {v[`RTCAW_B_PM], v[7:6], ~v[`RTCAW_B_PM],
                      `RTCAW_H12_NOON};
        else begin
          t = bcd_inc({3'b000, v[4:0]}, `RTCAW_ONE, `RTCAW_HUND_LAST);
          hour_inc = {1'b0, v[7:5], t[4:0]};
        end
      end else begin
        t = bcd_inc({2'b00, v[5:0]}, `RTCAW_ZERO, `RTCAW_H24_LAST);
        hour_inc = {t[8], v[7:6], t[5:0]};
      end
    end
  endfunction

  // Last date of a month, with leap years from the BCD year
  function [7:0] last_date;
    input [7:0] mon;
    input [7:0] yr;
    reg         leap;
    begin
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                      yr[3:0] == 4'h8);
      case (mon[4:0])
        5'h02:   last_date = leap ? 8'h29 : 8'h28;
        5'h04,
        5'h06,
        5'h09,
        5'h11:   last_date = 8'h30;
        default: last_date = 8'h31;
      endcase
    end
  endfunction

  // Four-digit BCD decrement
  function [15:0] bcd_dec;
    input [15:0] v;
    integer      i;
    reg          b;
    begin
      b = 1'b1;
      bcd_dec = v;
      for (i = 0; i < 4; i = i + 1) begin
        if (b) begin
          if (v[i*4 +: 4] == 4'h0)
            bcd_dec[i*4 +: 4] = 4'h9;
          else begin
            bcd_dec[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
            b = 1'b0;
          end
        end
      end
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire [PW-1:0] pins = {osc_in, vcc_below_supply_trip_point, ce_n, oe_n,
                        we_n, addr, dq_in};
  reg  [PW-1:0] sync1;
  reg  [PW-1:0] sync2;
  reg  [PW-1:0] sync3;
  reg  [PW-1:0] filt;

  // Three stages, then accept a level once the last two agree
  // All stages reset to idle levels, so no false strobe follows reset
  always @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= `RTCAW_PIN_IDLE;
      sync2 <= `RTCAW_PIN_IDLE;
      sync3 <= `RTCAW_PIN_IDLE;
      filt  <= `RTCAW_PIN_IDLE;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= agree(sync2, sync3, filt);
    end
  end

  wire       f_osc   = filt[18];
  wire       f_below = filt[17];
  wire       f_ce_n  = filt[16];
  wire       f_oe_n  = filt[15];
  wire       f_we_n  = filt[14];
  wire [5:0] f_addr  = filt[13:8];
  wire [7:0] f_dq    = filt[7:0];

  // Bus decode; nothing is seen while the supply is low
  wire acc    = ~f_ce_n & (~f_we_n | ~f_oe_n) & ~f_below;
  wire wr     = ~f_ce_n & ~f_we_n & ~f_below;
  assign dq_oe = ~f_ce_n & ~f_oe_n & f_we_n & ~f_below;

  // ****************************************************************
  // Register state
  // ****************************************************************
  reg  [7:0]  vis_hund, vis_sec, vis_min, vis_hour;
  reg  [7:0]  vis_day, vis_date, vis_month, vis_year;
  reg  [7:0]  int_hund, int_sec, int_min, int_hour;
  reg  [7:0]  int_day, int_date, int_month, int_year;
  reg  [7:0]  alm_min, alm_hour, alm_day;
  reg  [7:0]  wd_lo, wd_hi;
  reg  [15:0] wd_cnt;
  reg  [7:0]  cmd;
  reg         alarm_match_flag;
  reg         watchdog_expiry_flag;
  reg         osc_q, acc_q, wr_q;
  reg  [5:0]  addr_q;
  reg  [7:0]  dq_q;
  reg  [5:0]  div_cnt;
  reg  [4:0]  div_step;
  reg  [1:0]  wave_div;

  wire oscillator_stop     = vis_month[`RTCAW_B_OSC_STOP];
  wire transfer_enable_bit = cmd[`RTCAW_B_XFER];
  wire watchdog_interrupt_mask = cmd[`RTCAW_B_WDMASK];
  wire alarm_interrupt_mask    = cmd[`RTCAW_B_TDM];

  // Oscillator edge, gated by the stop bit
  wire osc_tick = f_osc & ~osc_q & ~oscillator_stop;

  // Divider: last of the 25 steps is one cycle shorter
  wire [5:0] div_len = (div_step == `RTCAW_DIV_STEPS - 5'd1) ?
                       `RTCAW_DIV_SHORT : `RTCAW_DIV_LONG;
  wire hund_tick = osc_tick & (div_cnt == div_len - 6'd1);

  // ****************************************************************
  // Next calendar values
  // ****************************************************************
  wire [8:0]  n_hund  = bcd_inc(int_hund, `RTCAW_ZERO, `RTCAW_HUND_LAST);
  wire [8:0]  n_sec   = bcd_inc(int_sec, `RTCAW_ZERO, `RTCAW_SEC_LAST);
  wire [8:0]  n_min   = bcd_inc(int_min, `RTCAW_ZERO, `RTCAW_SEC_LAST);
  wire [8:0]  n_hour  = hour_inc(int_hour);
  wire [8:0]  n_day   = bcd_inc(int_day, `RTCAW_ONE, `RTCAW_DAY_LAST);
  wire [8:0]  n_date  = bcd_inc(int_date, `RTCAW_ONE,
                                last_date(int_month, int_year));
  wire [8:0]  n_month = bcd_inc(int_month, `RTCAW_ONE, `RTCAW_MON_LAST);
  wire [8:0]  n_year  = bcd_inc(int_year, `RTCAW_ZERO, `RTCAW_HUND_LAST);
  wire        step_up = hund_tick & (int_hund == `RTCAW_HUND_PRE);
  wire        wrap    = hund_tick & (int_hund == `RTCAW_HUND_LAST);
  wire        c_min   = n_sec[8];
  wire        c_hour  = c_min & n_min[8];
  wire        c_day   = c_hour & n_hour[8];
  wire        c_month = c_day & n_date[8];
  wire        c_year  = c_month & n_month[8];
  wire [7:0]  nx_min  = c_min ? n_min[7:0] : int_min;
  wire [7:0]  nx_hour = c_hour ? n_hour[7:0] : int_hour;
  wire [7:0]  nx_day  = c_day ? n_day[7:0] : int_day;

  // Alarm check at the minute boundary; masks widen the match
  wire alarm_hit = step_up & c_min &
    (alm_min[`RTCAW_B_AMASK]  | (nx_min  == alm_min))  &
    (alm_hour[`RTCAW_B_AMASK] | (nx_hour == alm_hour)) &
    (alm_day[`RTCAW_B_AMASK]  | (nx_day  == (alm_day & `RTCAW_M_DAY)));

  // Watchdog period and expiry
  wire [15:0] wd_period = {wd_hi, wd_lo};
  wire        wd_on     = (wd_period != 16'h0000);
  wire        wd_expire = hund_tick & wd_on &
                          (wd_cnt <= 16'h0001);

  // Access start and write completion
  wire acc_start = acc & ~acc_q;
  wire wr_done   = wr_q & ~wr & ~f_below;
  wire alm_sel   = (f_addr == `RTCAW_A_AMIN) | (f_addr == `RTCAW_A_AHOUR) |
                   (f_addr == `RTCAW_A_ADAY);
  wire wd_sel    = (f_addr == `RTCAW_A_WDLO) | (f_addr == `RTCAW_A_WDHI);
  wire wd_wsel   = (addr_q == `RTCAW_A_WDLO) | (addr_q == `RTCAW_A_WDHI);

  // ****************************************************************
  // Read data
  // ****************************************************************
  reg [7:0] next_dq;

  // Unused bits are masked here as well as on host writes to storage
  always @* begin
    case (f_addr)
      `RTCAW_A_HUND:  next_dq = vis_hund;
      `RTCAW_A_SEC:   next_dq = vis_sec & `RTCAW_M_SEC;
      `RTCAW_A_MIN:   next_dq = vis_min & `RTCAW_M_MIN;
      `RTCAW_A_AMIN:  next_dq = alm_min;
      `RTCAW_A_HOUR:  next_dq = vis_hour & `RTCAW_M_HOUR;
      `RTCAW_A_AHOUR: next_dq = alm_hour;
      `RTCAW_A_DAY:   next_dq = vis_day & `RTCAW_M_DAY;
      `RTCAW_A_ADAY:  next_dq = alm_day & `RTCAW_M_ADAY;
      `RTCAW_A_DATE:  next_dq = vis_date & `RTCAW_M_DATE;
      `RTCAW_A_MONTH: next_dq = vis_month & `RTCAW_M_MONTH;
      `RTCAW_A_YEAR:  next_dq = vis_year;
      `RTCAW_A_CMD:   next_dq = {cmd[7:2], watchdog_expiry_flag,
                                 alarm_match_flag};
      `RTCAW_A_WDLO:  next_dq = wd_lo;
      `RTCAW_A_WDHI:  next_dq = wd_hi;
      default:        next_dq = 8'h00;
    endcase
  end

  // ****************************************************************
  // Main state
  // ****************************************************************

  // Counters first, host writes after them so a write beats the counters the same cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      {vis_hund, vis_sec, vis_min, vis_hour} <= 32'h0000_0000;
      {int_hund, int_sec, int_min, int_hour} <= 32'h0000_0000;
      vis_day   <= `RTCAW_ONE;
      vis_date  <= `RTCAW_ONE;
      vis_month <= `RTCAW_RST_MONTH;
      vis_year  <= `RTCAW_ZERO;
      int_day   <= `RTCAW_ONE;
      int_date  <= `RTCAW_ONE;
      int_month <= `RTCAW_ONE;
      int_year  <= `RTCAW_ZERO;
      {alm_min, alm_hour, alm_day} <= 24'h000000;
      {wd_lo, wd_hi} <= 16'h0000;
      wd_cnt    <= 16'h0000;
      cmd       <= `RTCAW_RST_CMD;
      alarm_match_flag     <= 1'b0;
      watchdog_expiry_flag <= 1'b0;
      {osc_q, acc_q, wr_q} <= 3'b000;
      addr_q    <= 6'h00;
      dq_q      <= 8'h00;
      div_cnt   <= 6'd0;
      div_step  <= 5'd0;
      wave_div  <= 2'b00;
      dq_out    <= 8'h00;
      square_wave_out <= 1'b0;
      square_wave_oe  <= 1'b0;
      alarm_irq       <= 1'b0;
      watchdog_irq    <= 1'b0;
    end else begin
      osc_q  <= f_osc;
      acc_q  <= acc;
      wr_q   <= wr;
      addr_q <= f_addr;
      dq_q   <= f_dq;
      dq_out <= next_dq;

      // Fractional divider and square-wave prescaler
      if (osc_tick) begin
        wave_div <= wave_div + 2'b01;
        if (div_cnt == div_len - 6'd1) begin
          div_cnt  <= 6'd0;
          div_step <= (div_step == `RTCAW_DIV_STEPS - 5'd1) ?
                      5'd0 : div_step + 5'd1;
        end else
          div_cnt <= div_cnt + 6'd1;
      end
      square_wave_out <= wave_div[`RTCAW_WAVE_BIT];
      square_wave_oe  <= ~vis_month[`RTCAW_B_WAVE_OFF];

      // Internal counters always run while the oscillator does
      if (hund_tick)
        int_hund <= n_hund[7:0];
      if (step_up) begin
        int_sec  <= n_sec[7:0];
        int_min  <= nx_min;
        int_hour <= nx_hour;
        int_day  <= nx_day;
        if (c_day)
          int_date <= n_date[7:0];
        if (c_month)
          int_month <= n_month[7:0];
        if (c_year)
          int_year <= n_year[7:0];
      end

      // Visible copy: hundredths each tick, the rest on the wrap
      if (hund_tick & transfer_enable_bit) begin
        vis_hund <= n_hund[7:0];
        if (wrap) begin
          vis_sec   <= int_sec;
          vis_min   <= int_min;
          vis_hour  <= int_hour;
          vis_day   <= int_day;
          vis_date  <= int_date;
          vis_month <= {vis_month[7:6], int_month[5:0]};
          vis_year  <= int_year;
        end
      end

      // Watchdog countdown with repeating reload
      if (hund_tick & wd_on) begin
        if (wd_expire)
          wd_cnt <= wd_period;
        else
          wd_cnt <= bcd_dec(wd_cnt);
      end

      // Access start clears flags and restarts the watchdog
      if (acc_start & alm_sel)
        alarm_match_flag <= 1'b0;
      if (acc_start & wd_sel) begin
        watchdog_expiry_flag <= 1'b0;
        wd_cnt <= wd_period;
      end

      // Host writes land in both copies so time is not lost
      if (wr_done) begin
        case (addr_q)
          `RTCAW_A_HUND: begin
            vis_hund <= dq_q;
            int_hund <= dq_q;
          end
          `RTCAW_A_SEC: begin
            vis_sec <= dq_q & `RTCAW_M_SEC;
            int_sec <= dq_q & `RTCAW_M_SEC;
          end
          `RTCAW_A_MIN: begin
            vis_min <= dq_q & `RTCAW_M_MIN;
            int_min <= dq_q & `RTCAW_M_MIN;
          end
          `RTCAW_A_HOUR: begin
            vis_hour <= dq_q & `RTCAW_M_HOUR;
            int_hour <= dq_q & `RTCAW_M_HOUR;
          end
          `RTCAW_A_DAY: begin
            vis_day <= dq_q & `RTCAW_M_DAY;
            int_day <= dq_q & `RTCAW_M_DAY;
          end
          `RTCAW_A_DATE: begin
            vis_date <= dq_q & `RTCAW_M_DATE;
            int_date <= dq_q & `RTCAW_M_DATE;
          end
          `RTCAW_A_MONTH: begin
            vis_month <= dq_q & `RTCAW_M_MONTH;
            int_month <= dq_q & `RTCAW_M_MONNUM;
          end
          `RTCAW_A_YEAR: begin
            vis_year <= dq_q;
            int_year <= dq_q;
          end
          `RTCAW_A_AMIN:  alm_min  <= dq_q;
          `RTCAW_A_AHOUR: alm_hour <= dq_q;
          `RTCAW_A_ADAY:  alm_day  <= dq_q & `RTCAW_M_ADAY;
          `RTCAW_A_CMD:
            cmd <= {dq_q[7:2], 2'b00};
          `RTCAW_A_WDLO: begin
            wd_lo  <= dq_q;
            wd_cnt <= {wd_hi, dq_q};
          end
          `RTCAW_A_WDHI: begin
            wd_hi  <= dq_q;
            wd_cnt <= {dq_q, wd_lo};
          end
          default: ;
        endcase
        if (wd_wsel)
          watchdog_expiry_flag <= 1'b0;
      end

      // Flag sets come last so a set beats a clear in one cycle
      if (alarm_hit)
        alarm_match_flag <= 1'b1;
      if (wd_expire)
        watchdog_expiry_flag <= 1'b1;

      // Masks only gate the outputs
      alarm_irq    <= alarm_match_flag & ~alarm_interrupt_mask;
      watchdog_irq <= watchdog_expiry_flag &
                      ~watchdog_interrupt_mask;
    end
  end

endmodule

`default_nettype wire

/* File: testbench/rtcaw_core_properties.sv */
// Pin-level assertions for the timekeeper core
`timescale 1ns/1ps
`default_nettype none
module rtcaw_props (
  input wire logic       clk,                         // Clock
  input wire logic       sys_rst,                     // Reset
  input wire logic       osc_in,                      // Oscillator
  input wire logic       vcc_below_supply_trip_point, // Low supply
  input wire logic       ce_n,                        // Select
  input wire logic       oe_n,                        // Read strobe
  input wire logic       we_n,                        // Write strobe
  input wire logic [5:0] addr,                        // Address
  input wire logic       dq_oe,                       // Data drive
  input wire logic       square_wave_out,             // Square wave
  input wire logic       alarm_irq,                   // Alarm irq
  input wire logic       watchdog_irq                 // Watchdog irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Read cycle as the pins show it; pin sync delay is well under 8
  wire logic rd_ok = !ce_n && !oe_n && we_n && !vcc_below_supply_trip_point;
  a_read_drive: assert property (rd_ok [*8] |=> dq_oe)
    else $error("read cycle not driven");
  a_idle_quiet: assert property (ce_n [*8] |=> !dq_oe)
    else $error("data driven while deselected");
  a_supply_block: assert property
    (vcc_below_supply_trip_point [*8] |=> !dq_oe)
    else $error("data driven on low supply");
  a_wave_follow: assert property
    ($stable(osc_in) [*8] ##1 $stable(osc_in) [*8]
     |=> $stable(square_wave_out))
    else $error("square wave moved without oscillator");
  a_alarm_clear: assert property
    ((rd_ok && addr == 6'h03 && $stable(osc_in)) [*8] |=> !alarm_irq)
    else $error("alarm irq survived alarm read");
  a_wd_clear: assert property
    ((rd_ok && addr == 6'h0c && $stable(osc_in)) [*8] |=> !watchdog_irq)
    else $error("watchdog irq survived period read");
  a_alarm_hold: assert property
    (($stable(osc_in) && ce_n) [*8] ##1 ($stable(osc_in) && ce_n) [*8]
     |=> $stable(alarm_irq))
    else $error("alarm irq moved while idle");
  a_wd_hold: assert property
    (($stable(osc_in) && ce_n) [*8] ##1 ($stable(osc_in) && ce_n) [*8]
     |=> $stable(watchdog_irq))
    else $error("watchdog irq moved while idle");
endmodule
bind rtcaw_core rtcaw_props u_props (.clk(clk), .sys_rst(sys_rst),
  .osc_in(osc_in), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
  .vcc_below_supply_trip_point(vcc_below_supply_trip_point),
  .dq_oe(dq_oe), .square_wave_out(square_wave_out),
  .alarm_irq(alarm_irq), .watchdog_irq(watchdog_irq));
`default_nettype wire

/* File: testbench/rtcaw_host.sv */
// Host processor model driving the byte-wide register bus
`timescale 1ns/1ps
`default_nettype none
module rtcaw_host (
  input  wire logic       clk,   // Bench clock
  input  wire logic [7:0] rdata, // Device read data
  input  wire logic       rd_oe, // Device drives data
  output var  logic       ce_n,  // Chip select
  output var  logic       oe_n,  // Read strobe
  output var  logic       we_n,  // Write strobe
  output wire logic [5:0] addr,  // Register address
  output wire logic [7:0] wdata  // Write data
);
  logic       busy = 1'b0;
  logic       ph   = 1'b0;
  logic [5:0] a_r  = 6'h00;
  logic [7:0] d_r  = 8'h00;
  initial {ce_n, oe_n, we_n} = 3'b111;
  always @(negedge clk) ph <= !ph;
  // Released lines flip every cycle so a stale value never looks valid
  assign addr  = busy ? a_r : a_r ^ {6{ph}};
  assign wdata = busy ? d_r : d_r ^ {8{ph}};
  // One access; strobes held 8 cycles, pins kept 8 more after release
  task automatic access(input logic [5:0] a, input logic [7:0] d,
                        input logic wr, output logic [8:0] q);
    @(negedge clk);
    busy = 1'b1;
    a_r = a;
    d_r = d;
    {ce_n, oe_n, we_n} = {1'b0, wr, !wr};
    repeat (8) @(negedge clk);
    q = {rd_oe, rdata};
    {ce_n, oe_n, we_n} = 3'b111;
    repeat (8) @(negedge clk);
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_rtc_alarm_watchdog_core.sv */
// Self-checking bench for the timekeeper core
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_alarm_watchdog_core;
  logic            clk = 1'b0, sys_rst = 1'b1, osc_in = 1'b0;
  logic            vlow = 1'b0, run = 1'b0;
  wire logic       ce_n, oe_n, we_n, dq_oe, wave, wave_oe, a_irq, w_irq;
  wire logic [5:0] addr;
  wire logic [7:0] wdata, dq_out;
  int              n_errors = 0, cmp_count = 0, osc_n = 0, t0, i;
  logic      [8:0] q;
  logic      [7:0] v;
  logic      [7:0] hin [3] = '{8'h71, 8'h23, 8'h19};
  logic      [7:0] hexp [3] = '{8'h52, 8'h00, 8'h20};
  logic      [7:0] amin [3] = '{8'h80, 8'h30, 8'h00};
  initial forever #50 clk = ~clk;
  rtcaw_host u_host (.clk(clk), .rdata(dq_out), .rd_oe(dq_oe), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .addr(addr), .wdata(wdata));
  rtcaw_core dut (.clk(clk), .sys_rst(sys_rst), .osc_in(osc_in),
    .vcc_below_supply_trip_point(vlow), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .dq_in(wdata), .dq_out(dq_out),
    .dq_oe(dq_oe), .square_wave_out(wave), .square_wave_oe(wave_oe),
    .alarm_irq(a_irq), .watchdog_irq(w_irq));
  // Hundredths ticks after n counted edges: 24 periods of 41, one of 40
  function automatic int ticks(input int n);
    int t = 0;
    while (n >= ((t % 25 == 24) ? 40 : 41)) begin
      n -= (t % 25 == 24) ? 40 : 41;
      t++;
    end
    return t;
  endfunction
  function automatic logic [7:0] bcd(input int x);
    return 8'((x / 10 % 10) * 16 + x % 10);
  endfunction
  task automatic chk(input string nm, input logic [8:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_host.access(a, d, 1'b1, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e, string nm);
    u_host.access(a, 8'h00, 1'b0, q);
    chk(nm, {1'b1, e}, q);
  endtask
  // Oscillator edges only between accesses, so ticks never race the bus
  task automatic pulse(input int k);
    repeat (k) begin
      osc_in = 1'b1;
      repeat (4) @(negedge clk);
      osc_in = 1'b0;
      repeat (4) @(negedge clk);
      if (run) osc_n++;
    end
    repeat (12) @(negedge clk);
  endtask
  task automatic tick_to(input int k);
    while (ticks(osc_n) < k) pulse(1);
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    test_done;
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'hcca8ba92));
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    rd(6'h09, 8'h81, "month");
    wr(6'h0b, 8'hff);
    rd(6'h0b, 8'hfc, "cmd_ro");
    wr(6'h0b, 8'h80);
    for (i = 0; i < 8; i++) begin
      v = 8'($urandom);
      wr(6'h07, v);
      rd(6'h07, v & 8'h87, "aday");
      v = bcd($urandom_range(59)) | (v & 8'h80);
      wr(6'h03, v);
      rd(6'h03, v, "amin");
      v = bcd($urandom_range(99));
      wr(6'h0d, v);
      rd(6'h0d, v, "wdhi");
    end
    wr(6'h09, 8'h01);
    run = 1'b1;
    chk("wave_on", 9'h1, 9'(wave_oe));
    pulse(41);
    rd(6'h00, 8'h01, "hund41");
    pulse(983);
    rd(6'h00, 8'h25, "hund1024");
    v = {7'h0, wave};
    pulse(2);
    chk("wave", 9'(!v[0]), 9'(wave));
    wr(6'h09, 8'h41);
    chk("wave_off", 9'h0, 9'(wave_oe));
    t0 = ticks(osc_n);
    wr(6'h0b, 8'h00);
    tick_to(t0 + 2);
    rd(6'h00, bcd(t0 % 100), "frozen");
    wr(6'h0b, 8'h80);
    tick_to(t0 + 3);
    rd(6'h00, bcd((t0 + 3) % 100), "resumed");
    wr(6'h09, 8'hc1);
    run = 1'b0;
    pulse(82);
    rd(6'h00, bcd((t0 + 3) % 100), "stopped");
    wr(6'h09, 8'h41);
    run = 1'b1;
    // Hour rollover in both formats with three alarm minute settings, hours and day masked
    for (i = 0; i < 3; i++) begin
      wr(6'h05, 8'h80);
      wr(6'h07, 8'h80);
      wr(6'h03, amin[i]);
      wr(6'h04, hin[i]);
      wr(6'h02, 8'h59);
      wr(6'h01, 8'h59);
      wr(6'h00, 8'h98);
      tick_to(ticks(osc_n) + 2);
      rd(6'h04, hexp[i], "hour");
      chk("alarm", 9'(amin[i] != 8'h30), 9'(a_irq));
      rd(6'h03, amin[i], "amin_rd");
      chk("alarm_clr", 9'h0, 9'(a_irq));
    end
    wr(6'h0d, 8'h00);
    wr(6'h0c, 8'h03);
    t0 = ticks(osc_n);
    tick_to(t0 + 2);
    chk("wd_early", 9'h0, 9'(w_irq));
    tick_to(t0 + 3);
    chk("wd_fire", 9'h1, 9'(w_irq));
    rd(6'h0b, 8'h82, "cmd_flag");
    rd(6'h0c, 8'h03, "wdlo");
    chk("wd_clr", 9'h0, 9'(w_irq));
    t0 = ticks(osc_n);
    tick_to(t0 + 3);
    chk("wd_again", 9'h1, 9'(w_irq));
    wr(6'h0b, 8'h88);
    chk("wd_mask", 9'h0, 9'(w_irq));
    rd(6'h0b, 8'h8a, "flag_kept");
    wr(6'h0b, 8'h80);
    wr(6'h0c, 8'h00);
    tick_to(ticks(osc_n) + 8);
    chk("wd_off", 9'h0, 9'(w_irq));
    wr(6'h0a, 8'h21);
    vlow = 1'b1;
    repeat (8) @(negedge clk);
    u_host.access(6'h0a, 8'h55, 1'b1, q);
    u_host.access(6'h0a, 8'h00, 1'b0, q);
    chk("blocked", 9'h0, {q[8], 8'h00});
    vlow = 1'b0;
    repeat (8) @(negedge clk);
    rd(6'h0a, 8'h21, "year");
    test_done;
  end
endmodule
`default_nettype wire
